/* rtl/dls_desc_set.sv */
// One descriptor register set with its busy and outcome tracking
`timescale 1ns/1ps
module dls_desc_set (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register writes
	input wire logic wr_en,
	input wire logic [2:0] wr_reg,
	input wire logic [31:0] wr_data,
	// Engine handshake
	input wire logic take,
	input wire logic fin,
	input wire logic [2:0] fin_code,
	input wire logic fin_wait,
	input wire logic fin_irq,
	// Response and service
	input wire logic rsp_hit,
	input wire logic [2:0] rsp_code,
	input wire logic isr_done,
	// Status
	output logic queued,
	output logic busy,
	output logic [2:0] code,
	output logic irq,
	// Descriptors
	output logic [31:0] addr_msb,
	output logic [31:0] addr_lsb,
	output logic [31:0] dsp_addr,
	output logic [31:0] byte_cnt,
	output logic [31:0] routing,
	output logic [31:0] command
);
	dls_pkg::dls_slot_t state, next_state;
	logic [2:0] next_code;
	logic next_irq, next_busy;
	logic [11:0] tmo, next_tmo;
	logic [31:0] next_msb, next_lsb, next_dsp, next_cnt, next_rt, next_cmd;
	logic [2:0] end_code;
	logic end_now;

	// Next state of the set
	always_comb begin
		next_state = state;
		next_code = code;
		next_irq = irq;
		next_tmo = tmo;
		next_msb = addr_msb;
		next_lsb = addr_lsb;
		next_dsp = dsp_addr;
		next_cnt = byte_cnt;
		next_rt = routing;
		next_cmd = command;
		end_now = 1'b0;
		end_code = fin_code;
		if (wr_en && state == dls_pkg::DLS_SL_IDLE) begin
			unique case (wr_reg)
				dls_pkg::REG_ADDR_MSB: next_msb = wr_data;
				dls_pkg::REG_ADDR_LSB: next_lsb = wr_data;
				dls_pkg::REG_DSP_ADDR: next_dsp = wr_data;
				dls_pkg::REG_BYTE_CNT: next_cnt = wr_data;
				dls_pkg::REG_ROUTING: next_rt = wr_data;
				dls_pkg::REG_TRIGGER: begin
					next_cmd = wr_data;
					next_state = dls_pkg::DLS_SL_QUEUED;
					next_code = dls_pkg::CC_OK;
				end
				default: ;
			endcase
		end
		unique case (state)
			dls_pkg::DLS_SL_IDLE: ;
			dls_pkg::DLS_SL_QUEUED: begin
				if (take) begin
					next_state = dls_pkg::DLS_SL_ACTIVE;
				end
			end
			dls_pkg::DLS_SL_ACTIVE: begin
				if (fin && fin_wait) begin
					next_state = dls_pkg::DLS_SL_WAIT;
					next_tmo = dls_pkg::RSP_TIMEOUT_CNT;
				end else if (fin) begin
					end_now = 1'b1;
				end
			end
			dls_pkg::DLS_SL_WAIT: begin
				next_tmo = tmo - 12'h0001;
				if (rsp_hit) begin
					end_now = 1'b1;
					end_code = rsp_code;
				end else if (tmo == 12'h0000) begin
					end_now = 1'b1;
					end_code = dls_pkg::CC_TIMEOUT;
				end
			end
			dls_pkg::DLS_SL_ISR: begin
				if (isr_done) begin
					next_state = dls_pkg::DLS_SL_IDLE;
					next_irq = 1'b0;
				end
			end
			default: next_state = dls_pkg::DLS_SL_IDLE;
		endcase
		if (end_now) begin
			next_code = end_code;
			if (routing[dls_pkg::RT_IRQ_BIT] || fin_irq) begin
				next_state = dls_pkg::DLS_SL_ISR;
				next_irq = 1'b1;
			end else begin
				next_state = dls_pkg::DLS_SL_IDLE;
			end
		end
		next_busy = (next_state != dls_pkg::DLS_SL_IDLE);
	end

	// State registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= dls_pkg::DLS_SL_IDLE;
			busy <= 1'b0;
			code <= dls_pkg::CC_OK;
			irq <= 1'b0;
			tmo <= 12'h000;
			addr_msb <= dls_pkg::DESC_RST;
			addr_lsb <= dls_pkg::DESC_RST;
			dsp_addr <= dls_pkg::DESC_RST;
			byte_cnt <= dls_pkg::DESC_RST;
			routing <= dls_pkg::DESC_RST;
			command <= dls_pkg::DESC_RST;
		end else begin
			state <= next_state;
			busy <= next_busy;
			code <= next_code;
			irq <= next_irq;
			tmo <= next_tmo;
			addr_msb <= next_msb;
			addr_lsb <= next_lsb;
			dsp_addr <= next_dsp;
			byte_cnt <= next_cnt;
			routing <= next_rt;
			command <= next_cmd;
		end
	end

	// Set waits for the engine
	assign queued = (state == dls_pkg::DLS_SL_QUEUED);
endmodule

/* rtl/dls_pkg.sv */
// Shared constants of the direct I/O load/store unit
package dls_pkg;
	localparam int SETS = 4;
	// Descriptor register indices within one set
	localparam logic [2:0] REG_ADDR_MSB = 3'h0;
	localparam logic [2:0] REG_ADDR_LSB = 3'h1;
	localparam logic [2:0] REG_DSP_ADDR = 3'h2;
	localparam logic [2:0] REG_BYTE_CNT = 3'h3;
	localparam logic [2:0] REG_ROUTING = 3'h4;
	localparam logic [2:0] REG_TRIGGER = 3'h5;
	// Routing descriptor field positions
	localparam int RT_DEST_LSB = 0;
	localparam int RT_IDW_LSB = 16;
	localparam int RT_XAMSB_LSB = 18;
	localparam int RT_PRIO_LSB = 20;
	localparam int RT_PORT_LSB = 22;
	localparam int RT_IRQ_BIT = 24;
	// Command trigger field positions
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_HOP_LSB = 8;
	localparam int CMD_BELL_LSB = 16;
	// Reset values
	localparam logic [31:0] DESC_RST = 32'h0000_0000;
	// Outcome codes
	localparam logic [2:0] CC_OK = 3'h0;
	localparam logic [2:0] CC_TIMEOUT = 3'h1;
	localparam logic [2:0] CC_XOFF = 3'h2;
	localparam logic [2:0] CC_RSP_ERR = 3'h3;
	localparam logic [2:0] CC_BAD_ENC = 3'h4;
	localparam logic [2:0] CC_DMA_ERR = 3'h5;
	localparam logic [2:0] CC_RETRY = 3'h6;
	localparam logic [2:0] CC_NO_CREDIT = 3'h7;
	// Packet format types
	localparam logic [3:0] FT_READ = 4'h2;
	localparam logic [3:0] FT_WRITE = 4'h5;
	localparam logic [3:0] FT_SWRITE = 4'h6;
	localparam logic [3:0] FT_MAINT = 4'h8;
	localparam logic [3:0] FT_BELL = 4'hA;
	localparam logic [3:0] TR_NWRITE = 4'h4;
	localparam logic [3:0] TR_MAINT_WR = 4'h1;
	localparam logic [1:0] IDW_8 = 2'h0;
	localparam logic [1:0] IDW_16 = 2'h1;
	// Length coding: zero means the full block
	localparam logic [12:0] LEN_FULL = 13'h1000;
	// Response timeout for non-posted requests
	localparam int RSP_TIMEOUT_NS = 10000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [11:0] RSP_TIMEOUT_CNT = 12'(RSP_TIMEOUT_CYC);
	// Per-set state
	typedef enum logic [2:0] {
		DLS_SL_IDLE = 3'b000,
		DLS_SL_QUEUED = 3'b001,
		DLS_SL_ACTIVE = 3'b010,
		DLS_SL_WAIT = 3'b011,
		DLS_SL_ISR = 3'b100
	} dls_slot_t;
	// Engine state
	typedef enum logic [2:0] {
		DLS_EN_IDLE = 3'b000,
		DLS_EN_CHECK = 3'b001,
		DLS_EN_ALLOC = 3'b010,
		DLS_EN_DMA_REQ = 3'b011,
		DLS_EN_DMA_WAIT = 3'b100,
		DLS_EN_FWD = 3'b101,
		DLS_EN_DONE = 3'b110
	} dls_eng_t;
endpackage

/* rtl/dls_unit.sv */
// Direct I/O load/store unit: descriptor sets, packet engine and status
`timescale 1ns/1ps
// Operation
// - Low four kind bits become the transaction subfield for types 2, 5, 8.
// - Bell info is copied into the doorbell field of type 10 packets.
// - Hop count is copied into the header only for type 8 packets.
// - Interrupt request bit set raises an interrupt when the command finishes.
// - Busy is 1 during a transfer, 0 when descriptors may be rewritten.
// - Codes 000 ok, 001 response timeout, 010 Xoff blockade.
// - Codes 011 response error, 100 bad encoding, 101 DMA error.
// - Codes 110 retry or refused semaphore, 111 no outbound credit.
// - Four independent descriptor sets allow four outstanding requests.
// - Busy rises the cycle after the trigger write; old code invalidated.
// - Busy clears and code becomes valid after end and interrupt service.
// - Write payload joins descriptor header in TX buffer, then goes out.
// - Reads build a payload-free read packet from descriptors only.
// - Read response payloads are held in the shared RX buffer.
// - Output port select picks the TX FIFO and is not in the header.
// - All direct I/O reads, writes and doorbells leave through this unit.
// - Priority flow is checked for Xoff after encoding, before credit.
// - Free space of the selected TX FIFO is checked before starting.
// - Payload DMA read is issued only after flow grant and allocation.
// - Packets go out in DMA completion order.
// - Shut-down flow interrupts, sets 010 and holds busy through service.
// - A transfer starts when the command trigger write completes.
// - Length 1 to 4095 bytes, zero means 4K bytes.
// - Device ID width 00 selects 8-bit, 01 16-bit, others reserved.
// - High four kind bits become ftype for every packet.
module dls_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Descriptor writes from the CPU
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_set,
	input wire logic [2:0] cfg_reg,
	input wire logic [31:0] cfg_wdata,
	// Per-set status and service
	output logic [3:0] command_busy,
	output logic [11:0] outcome_code,
	output logic [3:0] irq,
	input wire logic [3:0] isr_done,
	// Flow control and credit
	input wire logic [3:0] xoff_any,
	input wire logic [3:0] credit_ok,
	input wire logic [3:0] fifo_space,
	// DMA bus
	output logic dma_req,
	output logic [31:0] dma_addr,
	output logic [12:0] dma_len,
	output logic [1:0] dma_buf,
	input wire logic dma_ack,
	input wire logic dma_done,
	input wire logic dma_err,
	// Packet to TX FIFO
	output logic pkt_valid,
	output logic [1:0] pkt_port,
	output logic [3:0] pkt_ftype,
	output logic [3:0] pkt_trans,
	output logic [1:0] pkt_tt,
	output logic [1:0] pkt_prio,
	output logic [15:0] pkt_dest,
	output logic [63:0] pkt_addr,
	output logic [1:0] pkt_xamsb,
	output logic [7:0] pkt_hop,
	output logic [15:0] pkt_bell,
	output logic [12:0] pkt_len,
	output logic pkt_payload,
	output logic [1:0] pkt_tid,
	input wire logic pkt_ready,
	// Responses
	input wire logic rsp_valid,
	input wire logic [1:0] rsp_tid,
	input wire logic [2:0] rsp_code,
	input wire logic rsp_beat,
	input wire logic [127:0] rsp_data,
	// Shared RX buffer write
	output logic rxbuf_we,
	output logic [1:0] rxbuf_set,
	output logic [127:0] rxbuf_data
);
	logic [31:0] d_msb [4];
	logic [31:0] d_lsb [4];
	logic [31:0] d_dsp [4];
	logic [31:0] d_cnt [4];
	logic [31:0] d_rt [4];
	logic [31:0] d_cmd [4];
	logic [3:0] s_queued, s_busy, s_irq, s_take, s_fin;
	logic [2:0] s_code [4];
	dls_pkg::dls_eng_t state, next_state;
	logic [1:0] cur, next_cur;
	logic [2:0] f_code, next_f_code;
	logic f_wait, next_f_wait, f_irq, next_f_irq;
	logic next_dma_req;
	logic next_pkt_valid;
	logic next_rxbuf_we;
	logic [31:0] rt, cmd;
	logic [3:0] ftype, trans;
	logic [1:0] prio, port, idw;
	logic has_payload, non_posted, enc_ok;
	logic [12:0] len;

	// Four descriptor sets
	for (genvar g = 0; g < dls_pkg::SETS; g++) begin : g_set
		dls_desc_set u_set (
			.clk(clk),
			.sys_rst(sys_rst),
			.wr_en(cfg_wr && cfg_set == 2'(g)),
			.wr_reg(cfg_reg),
			.wr_data(cfg_wdata),
			.take(s_take[g]),
			.fin(s_fin[g]),
			.fin_code(f_code),
			.fin_wait(f_wait),
			.fin_irq(f_irq),
			.rsp_hit(rsp_valid && rsp_tid == 2'(g)),
			.rsp_code(rsp_code),
			.isr_done(isr_done[g]),
			.queued(s_queued[g]),
			.busy(s_busy[g]),
			.code(s_code[g]),
			.irq(s_irq[g]),
			.addr_msb(d_msb[g]),
			.addr_lsb(d_lsb[g]),
			.dsp_addr(d_dsp[g]),
			.byte_cnt(d_cnt[g]),
			.routing(d_rt[g]),
			.command(d_cmd[g])
		);
		assign s_take[g] = (state == dls_pkg::DLS_EN_IDLE) && (next_cur == 2'(g)) &&
			s_queued[g];
		assign s_fin[g] = (state == dls_pkg::DLS_EN_DONE) && (cur == 2'(g));
	end

	// Status outputs come from the set registers
	always_comb begin
		for (int i = 0; i < dls_pkg::SETS; i++) begin
			command_busy[i] = s_busy[i];
			irq[i] = s_irq[i];
			outcome_code[3*i +: 3] = s_code[i];
		end
	end

	// Field decode of the set being served
	always_comb begin
		rt = d_rt[cur];
		cmd = d_cmd[cur];
		ftype = cmd[dls_pkg::CMD_KIND_LSB+4 +: 4];
		trans = cmd[dls_pkg::CMD_KIND_LSB +: 4];
		prio = rt[dls_pkg::RT_PRIO_LSB +: 2];
		port = rt[dls_pkg::RT_PORT_LSB +: 2];
		idw = rt[dls_pkg::RT_IDW_LSB +: 2];
		len = (d_cnt[cur][11:0] == 12'h000) ? dls_pkg::LEN_FULL :
			{1'b0, d_cnt[cur][11:0]};
		has_payload = (ftype == dls_pkg::FT_WRITE) || (ftype == dls_pkg::FT_SWRITE) ||
			(ftype == dls_pkg::FT_MAINT && trans == dls_pkg::TR_MAINT_WR);
		non_posted = !(ftype == dls_pkg::FT_SWRITE ||
			(ftype == dls_pkg::FT_WRITE && trans == dls_pkg::TR_NWRITE));
		enc_ok = (idw == dls_pkg::IDW_8 || idw == dls_pkg::IDW_16) &&
			(ftype == dls_pkg::FT_READ || ftype == dls_pkg::FT_WRITE ||
			ftype == dls_pkg::FT_SWRITE || ftype == dls_pkg::FT_MAINT ||
			ftype == dls_pkg::FT_BELL);
	end

	// Engine next state
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_f_code = f_code;
		next_f_wait = f_wait;
		next_f_irq = f_irq;
		next_dma_req = dma_req;
		next_pkt_valid = pkt_valid;
		unique case (state)
			dls_pkg::DLS_EN_IDLE: begin
				// Rotating pick among queued sets
				for (int k = 3; k >= 0; k--) begin
					if (s_queued[2'(cur + 2'(k) + 2'h1)]) begin
						next_cur = 2'(cur + 2'(k) + 2'h1);
					end
				end
				if (s_queued != 4'h0) begin
					next_state = dls_pkg::DLS_EN_CHECK;
				end
			end
			dls_pkg::DLS_EN_CHECK: begin
				next_f_wait = 1'b0;
				next_f_irq = 1'b0;
				next_state = dls_pkg::DLS_EN_DONE;
				if (!enc_ok) begin
					next_f_code = dls_pkg::CC_BAD_ENC;
				end else if (xoff_any[prio]) begin
					next_f_code = dls_pkg::CC_XOFF;
					next_f_irq = 1'b1;
				end else if (!credit_ok[prio]) begin
					next_f_code = dls_pkg::CC_NO_CREDIT;
				end else begin
					next_f_code = dls_pkg::CC_OK;
					next_state = dls_pkg::DLS_EN_ALLOC;
				end
			end
			dls_pkg::DLS_EN_ALLOC: begin
				if (fifo_space[port]) begin
					if (has_payload) begin
						next_state = dls_pkg::DLS_EN_DMA_REQ;
						next_dma_req = 1'b1;
					end else begin
						next_state = dls_pkg::DLS_EN_FWD;
						next_pkt_valid = 1'b1;
					end
				end
			end
			dls_pkg::DLS_EN_DMA_REQ: begin
				if (dma_ack) begin
					next_dma_req = 1'b0;
					next_state = dls_pkg::DLS_EN_DMA_WAIT;
				end
			end
			dls_pkg::DLS_EN_DMA_WAIT: begin
				if (dma_err) begin
					next_f_code = dls_pkg::CC_DMA_ERR;
					next_state = dls_pkg::DLS_EN_DONE;
				end else if (dma_done) begin
					next_state = dls_pkg::DLS_EN_FWD;
					next_pkt_valid = 1'b1;
				end
			end
			dls_pkg::DLS_EN_FWD: begin
				if (pkt_ready) begin
					next_pkt_valid = 1'b0;
					next_f_wait = non_posted;
					next_state = dls_pkg::DLS_EN_DONE;
				end
			end
			dls_pkg::DLS_EN_DONE: next_state = dls_pkg::DLS_EN_IDLE;
			default: next_state = dls_pkg::DLS_EN_IDLE;
		endcase
	end

	// Engine registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= dls_pkg::DLS_EN_IDLE;
			cur <= 2'h3;
			f_code <= dls_pkg::CC_OK;
			f_wait <= 1'b0;
			f_irq <= 1'b0;
			dma_req <= 1'b0;
			pkt_valid <= 1'b0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			f_code <= next_f_code;
			f_wait <= next_f_wait;
			f_irq <= next_f_irq;
			dma_req <= next_dma_req;
			pkt_valid <= next_pkt_valid;
		end
	end

	// DMA request fields, loaded as the request rises
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dma_addr <= 32'h0000_0000;
			dma_len <= 13'h0000;
			dma_buf <= 2'h0;
		end else if (next_dma_req && !dma_req) begin
			dma_addr <= d_dsp[cur];
			dma_len <= len;
			dma_buf <= cur;
		end
	end

	// Packet header built from the descriptors as the packet is offered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pkt_port <= 2'h0;
			pkt_ftype <= 4'h0;
			pkt_trans <= 4'h0;
			pkt_tt <= 2'h0;
			pkt_prio <= 2'h0;
			pkt_dest <= 16'h0000;
			pkt_addr <= 64'h0000_0000_0000_0000;
			pkt_xamsb <= 2'h0;
			pkt_hop <= 8'h00;
			pkt_bell <= 16'h0000;
			pkt_len <= 13'h0000;
			pkt_payload <= 1'b0;
			pkt_tid <= 2'h0;
		end else if (next_pkt_valid && !pkt_valid) begin
			pkt_port <= port;
			pkt_ftype <= ftype;
			pkt_trans <= (ftype == dls_pkg::FT_READ || ftype == dls_pkg::FT_WRITE ||
				ftype == dls_pkg::FT_MAINT) ? trans : 4'h0;
			pkt_tt <= idw;
			pkt_prio <= prio;
			pkt_dest <= rt[dls_pkg::RT_DEST_LSB +: 16];
			pkt_addr <= {d_msb[cur], d_lsb[cur]};
			pkt_xamsb <= rt[dls_pkg::RT_XAMSB_LSB +: 2];
			pkt_hop <= (ftype == dls_pkg::FT_MAINT) ? cmd[dls_pkg::CMD_HOP_LSB +: 8] :
				8'h00;
			pkt_bell <= (ftype == dls_pkg::FT_BELL) ? cmd[dls_pkg::CMD_BELL_LSB +: 16] :
				16'h0000;
			pkt_len <= len;
			pkt_payload <= has_payload;
			pkt_tid <= cur;
		end
	end

	// Read response payload beats into the shared RX buffer
	assign next_rxbuf_we = rsp_beat;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxbuf_we <= 1'b0;
			rxbuf_set <= 2'h0;
			rxbuf_data <= 128'h0;
		end else begin
			rxbuf_we <= next_rxbuf_we;
			rxbuf_set <= rsp_tid;
			rxbuf_data <= rsp_data;
		end
	end
endmodule

/* tb/dls_far_model.sv */
// Behavioural DMA bus, TX FIFO and response source facing the unit
`timescale 1ns/1ps
module dls_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Scenario controls
	input wire logic [3:0] dly,
	input wire logic dma_fail,
	input wire logic rsp_on,
	input wire logic [2:0] rsp_val,
	// DMA bus
	input wire logic dma_req,
	output logic dma_ack,
	output logic dma_done,
	output logic dma_err,
	// TX FIFO
	input wire logic pkt_valid,
	input wire logic [3:0] pkt_ftype,
	input wire logic [3:0] pkt_trans,
	input wire logic [1:0] pkt_tid,
	output logic pkt_ready,
	// Responses
	output logic rsp_valid,
	output logic [1:0] rsp_tid,
	output logic [2:0] rsp_code,
	output logic rsp_beat,
	output logic [127:0] rsp_data
);
	logic np, rd;
	logic [1:0] tid;
	// Payload fetch: accept after a delay, then end or fail
	initial begin
		dma_ack = 1'b0;
		dma_done = 1'b0;
		dma_err = 1'b0;
		forever begin
			@(posedge clk);
			if (dma_req === 1'b1 && sys_rst === 1'b0) begin
				repeat (dly) @(posedge clk);
				dma_ack <= 1'b1;
				@(posedge clk);
				dma_ack <= 1'b0;
				repeat (dly) @(posedge clk);
				dma_err <= dma_fail;
				dma_done <= ~dma_fail;
				@(posedge clk);
				dma_err <= 1'b0;
				dma_done <= 1'b0;
			end
		end
	end
	// Packet sink; answers non-posted requests by their tag
	initial begin
		pkt_ready = 1'b0;
		rsp_valid = 1'b0;
		rsp_tid = 2'h0;
		rsp_code = 3'h0;
		rsp_beat = 1'b0;
		rsp_data = '0;
		forever begin
			@(posedge clk);
			if (pkt_valid === 1'b1) begin
				repeat (dly) @(posedge clk);
				pkt_ready <= 1'b1;
				tid = pkt_tid;
				rd = pkt_ftype == dls_pkg::FT_READ;
				np = !(pkt_ftype == dls_pkg::FT_SWRITE
					|| (pkt_ftype == dls_pkg::FT_WRITE && pkt_trans == dls_pkg::TR_NWRITE));
				@(posedge clk);
				pkt_ready <= 1'b0;
				if (np && rsp_on) begin
					repeat (3) @(posedge clk);
					rsp_beat <= rd;
					rsp_tid <= tid;
					rsp_data <= {32{tid, 2'h2}};
					@(posedge clk);
					rsp_beat <= 1'b0;
					rsp_data <= ~rsp_data;
					rsp_valid <= 1'b1;
					rsp_code <= rsp_val;
					@(posedge clk);
					rsp_valid <= 1'b0;
				end
			end
		end
	end
endmodule

/* tb/dls_unit_props.sv */
// Concurrent checks on the load/store unit ports
`timescale 1ns/1ps
module dls_unit_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Descriptor writes and status
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_set,
	input wire logic [2:0] cfg_reg,
	input wire logic [3:0] command_busy,
	input wire logic [11:0] outcome_code,
	input wire logic [3:0] irq,
	// DMA and packet side
	input wire logic dma_req,
	input wire logic dma_ack,
	input wire logic dma_done,
	input wire logic [12:0] dma_len,
	input wire logic pkt_valid,
	input wire logic pkt_ready,
	input wire logic [1:0] pkt_port,
	input wire logic [3:0] pkt_ftype,
	input wire logic pkt_payload,
	input wire logic [1:0] pkt_tid,
	// Responses and RX buffer
	input wire logic rsp_beat,
	input wire logic [1:0] rsp_tid,
	input wire logic [127:0] rsp_data,
	input wire logic rxbuf_we,
	input wire logic [1:0] rxbuf_set,
	input wire logic [127:0] rxbuf_data
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Trigger write to an idle set
	sequence s_trig;
		cfg_wr && cfg_reg == dls_pkg::REG_TRIGGER && !command_busy[cfg_set];
	endsequence
	property p_busy_rise;
		s_trig |=> command_busy[$past(cfg_set)];
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("Busy missing after trigger");
	property p_code_clear;
		s_trig |=> outcome_code[3*$past(cfg_set) +: 3] == dls_pkg::CC_OK;
	endproperty
	a_code_clear: assert property (p_code_clear)
		else $error("Old code kept");
	property p_dma_hold;
		dma_req && !dma_ack |=> dma_req && $stable(dma_len);
	endproperty
	a_dma_hold: assert property (p_dma_hold)
		else $error("DMA request dropped before accept");
	property p_len;
		dma_req |-> dma_len != 13'h0000 && dma_len <= dls_pkg::LEN_FULL;
	endproperty
	a_len: assert property (p_len)
		else $error("DMA length out of range");
	property p_pkt_hold;
		pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_port) && $stable(pkt_tid)
			&& $stable(pkt_ftype);
	endproperty
	a_pkt_hold: assert property (p_pkt_hold)
		else $error("Packet changed while offered");
	property p_read_bare;
		pkt_valid && pkt_ftype == dls_pkg::FT_READ |-> !pkt_payload;
	endproperty
	a_read_bare: assert property (p_read_bare)
		else $error("Read packet carries payload");
	property p_pay_after_dma;
		$rose(pkt_valid) && pkt_payload |-> $past(dma_done);
	endproperty
	a_pay_after_dma: assert property (p_pay_after_dma)
		else $error("Payload packet before fetch end");
	property p_rx_copy;
		rsp_beat |=> rxbuf_we && rxbuf_set == $past(rsp_tid) && rxbuf_data == $past(rsp_data);
	endproperty
	a_rx_copy: assert property (p_rx_copy)
		else $error("Response beat not stored");
	property p_irq_busy;
		((irq & ~$past(irq)) & ~command_busy) == 4'h0;
	endproperty
	a_irq_busy: assert property (p_irq_busy)
		else $error("Interrupt raised on idle set");
	property p_tid_busy;
		pkt_valid |-> command_busy[pkt_tid];
	endproperty
	a_tid_busy: assert property (p_tid_busy)
		else $error("Packet from idle set");
	// Main scenarios reached
	c_trig: cover property (s_trig);
	c_pkt: cover property (pkt_valid && pkt_ready);
	c_irq: cover property (irq != 4'h0);
endmodule
bind dls_unit dls_unit_chk i_chk (.clk, .sys_rst, .cfg_wr, .cfg_set, .cfg_reg,
	.command_busy, .outcome_code, .irq, .dma_req, .dma_ack, .dma_done, .dma_len,
	.pkt_valid, .pkt_ready, .pkt_port, .pkt_ftype, .pkt_payload, .pkt_tid, .rsp_beat,
	.rsp_tid, .rsp_data, .rxbuf_we, .rxbuf_set, .rxbuf_data);

/* tb/test_dls_unit.sv */
// Self-checking bench for the direct I/O load/store unit
`timescale 1ns/1ps
module test_dls_unit;
	// Stimulus, partner controls and observed ports
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr = 1'b0;
	logic [1:0] cfg_set = 2'h0;
	logic [2:0] cfg_reg = 3'h0;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [3:0] isr_done = 4'h0;
	logic [3:0] xoff_any = 4'h0;
	logic [3:0] credit_ok = 4'hF;
	logic [3:0] fifo_space = 4'hF;
	logic [3:0] dly = 4'h2;
	logic dma_fail = 1'b0;
	logic rsp_on = 1'b1;
	logic [2:0] rsp_val = 3'h0;
	logic [3:0] command_busy, irq, pkt_ftype, pkt_trans;
	logic [11:0] outcome_code;
	logic dma_req, dma_ack, dma_done, dma_err, pkt_valid, pkt_payload, pkt_ready;
	logic rsp_valid, rsp_beat, rxbuf_we, saw_irq;
	logic [31:0] dma_addr, last_hdr;
	logic [17:0] last_aux;
	logic [12:0] dma_len, pkt_len;
	logic [1:0] dma_buf, pkt_port, pkt_tt, pkt_prio, pkt_xamsb, pkt_tid, rsp_tid, rxbuf_set;
	logic [15:0] pkt_dest, pkt_bell;
	logic [63:0] pkt_addr;
	logic [7:0] pkt_hop;
	logic [2:0] rsp_code;
	logic [127:0] rsp_data, rxbuf_data;
	int n_pkt = 0;
	int p0 = 0;
	int n_mismatch = 0;
	int check_count = 0;
	// 125 MHz clock
	always #4 clk = ~clk;
	dls_unit i_dut (.clk, .sys_rst, .cfg_wr, .cfg_set, .cfg_reg, .cfg_wdata, .command_busy,
		.outcome_code, .irq, .isr_done, .xoff_any, .credit_ok, .fifo_space, .dma_req,
		.dma_addr, .dma_len, .dma_buf, .dma_ack, .dma_done, .dma_err, .pkt_valid,
		.pkt_port, .pkt_ftype, .pkt_trans, .pkt_tt, .pkt_prio, .pkt_dest, .pkt_addr,
		.pkt_xamsb, .pkt_hop, .pkt_bell, .pkt_len, .pkt_payload, .pkt_tid, .pkt_ready,
		.rsp_valid, .rsp_tid, .rsp_code, .rsp_beat, .rsp_data, .rxbuf_we, .rxbuf_set,
		.rxbuf_data);
	dls_far_model i_far (.clk, .sys_rst, .dly, .dma_fail, .rsp_on, .rsp_val, .dma_req,
		.dma_ack, .dma_done, .dma_err, .pkt_valid, .pkt_ftype, .pkt_trans, .pkt_tid,
		.pkt_ready, .rsp_valid, .rsp_tid, .rsp_code, .rsp_beat, .rsp_data);
	// Header of each packet taken
	always @(posedge clk) begin
		if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
			last_hdr <= {pkt_bell, pkt_hop, pkt_ftype, pkt_trans};
			last_aux <= {pkt_payload, pkt_tt, pkt_port, pkt_len};
			n_pkt <= n_pkt + 1;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic put(input logic [1:0] s, input logic [2:0] r, input logic [31:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_set <= s;
		cfg_reg <= r;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask
	// Load and trigger a set; busy must show
	task automatic start(input logic [1:0] s, input logic [31:0] len, input logic [31:0] rt,
		input logic [31:0] cmd);
		p0 = n_pkt;
		put(s, dls_pkg::REG_BYTE_CNT, len);
		put(s, dls_pkg::REG_ROUTING, rt);
		put(s, dls_pkg::REG_TRIGGER, cmd);
		#1 check(32'(command_busy[s]), 32'h0000_0001);
	endtask
	// Wait for release, serve the interrupt, judge
	task automatic finish(input logic [1:0] s, input logic [2:0] exp, input logic irq_exp,
		input int pk);
		int n;
		n = 0;
		saw_irq = 1'b0;
		while (command_busy[s] !== 1'b0) begin
			@(posedge clk);
			saw_irq = saw_irq | (irq[s] === 1'b1);
			isr_done <= (irq[s] === 1'b1 && isr_done[s] !== 1'b1) ? 4'h1 << s : 4'h0;
			n++;
			if (n > 3000) begin
				n_mismatch++;
				report_and_stop();
			end
		end
		check(32'(outcome_code[3*s +: 3]), 32'(exp));
		check(32'(saw_irq), 32'(irq_exp));
		if (pk >= 0) check(n_pkt - p0, pk);
	endtask
	task automatic t_swrite();
		fifo_space <= 4'hB;
		put(2'h0, dls_pkg::REG_DSP_ADDR, 32'h0000_8000);
		put(2'h0, dls_pkg::REG_ADDR_LSB, 32'h0000_0100);
		start(2'h0, 32'h0000_0000, 32'h0095_1234, 32'h0000_0060);
		repeat (12) @(posedge clk);
		check(32'(dma_req), 32'h0000_0000);
		fifo_space <= 4'hF;
		finish(2'h0, dls_pkg::CC_OK, 1'b0, 1);
		check(32'(last_hdr[7:0]), 32'h0000_0060);
		check(32'(last_aux), {14'h0, 1'b1, 2'h1, 2'h2, 13'h1000});
		check(32'({pkt_xamsb, pkt_prio, pkt_dest}), 32'h0005_1234);
		check(pkt_addr[31:0], 32'h0000_0100);
		check(dma_addr, 32'h0000_8000);
	endtask
	task automatic t_read();
		start(2'h1, 32'h0000_0010, 32'h0140_00AB, 32'h0000_0024);
		finish(2'h1, dls_pkg::CC_OK, 1'b1, 1);
		check(32'(last_hdr[7:0]), 32'h0000_0024);
		check(32'(last_aux), {14'h0, 1'b0, 2'h0, 2'h1, 13'h0010});
	endtask
	task automatic t_refuse();
		logic [31:0] rt [4] = '{32'h0030_0000, 32'h0000_0000, 32'h0000_0000, 32'h0002_0000};
		logic [31:0] cm [4] = '{32'h0000_0060, 32'h0000_0060, 32'h0000_0030, 32'h0000_0060};
		logic [2:0] cc [4] = '{3'h2, 3'h7, 3'h4, 3'h4};
		xoff_any <= 4'h8;
		credit_ok <= 4'hE;
		for (int i = 0; i < 4; i++) begin
			start(2'(i), 32'h0000_0010, rt[i], cm[i]);
			finish(2'(i), cc[i], 1'(i == 0), 0);
		end
		xoff_any <= 4'h0;
		credit_ok <= 4'hF;
	endtask
	task automatic t_dma_err();
		dma_fail <= 1'b1;
		start(2'h2, 32'h0000_0010, 32'h0000_0000, 32'h0000_0060);
		finish(2'h2, dls_pkg::CC_DMA_ERR, 1'b0, 0);
		check(32'(dma_buf), 32'h0000_0002);
		dma_fail <= 1'b0;
	endtask
	task automatic t_resp();
		logic [31:0] cm [4] = '{32'h1234_77A0, 32'h0000_5A81, 32'h0000_0055, 32'h0000_005E};
		logic [31:0] ex [4] = '{32'h1234_00A0, 32'h0000_5A81, 32'h0000_0055, 32'h0000_005E};
		logic [2:0] cc [4] = '{3'h6, 3'h3, 3'h0, 3'h6};
		dly <= 4'h6;
		for (int i = 0; i < 4; i++) begin
			rsp_val <= cc[i];
			start(2'h3, 32'h0000_0004, 32'h0000_0000, cm[i]);
			finish(2'h3, cc[i], 1'b0, 1);
			check(last_hdr, ex[i]);
		end
		dly <= 4'h2;
		rsp_val <= 3'h0;
	endtask
	task automatic t_timeout();
		rsp_on <= 1'b0;
		start(2'h2, 32'h0000_0010, 32'h0000_0000, 32'h0000_0024);
		repeat (20) @(posedge clk);
		put(2'h2, dls_pkg::REG_ROUTING, 32'h0100_0000);
		put(2'h2, dls_pkg::REG_TRIGGER, 32'h0000_0060);
		finish(2'h2, dls_pkg::CC_TIMEOUT, 1'b0, 1);
		rsp_on <= 1'b1;
	endtask
	task automatic t_multi();
		int p;
		p = n_pkt;
		start(2'h2, 32'h0000_0010, 32'h0000_0000, 32'h0000_0024);
		start(2'h3, 32'h0000_0010, 32'h0000_0000, 32'h0000_0024);
		check(32'(command_busy[3:2]), 32'h0000_0003);
		finish(2'h2, dls_pkg::CC_OK, 1'b0, -1);
		finish(2'h3, dls_pkg::CC_OK, 1'b0, -1);
		check(n_pkt - p, 2);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check(32'({command_busy, outcome_code}), 32'h0000_0000);
		t_swrite();
		t_read();
		t_refuse();
		t_dma_err();
		t_resp();
		t_timeout();
		t_multi();
		report_and_stop();
	end
endmodule
